// ### rtl/eeh_top.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "eeh_map.svh"

module eeh_top
  import eeh_pkg::*;
(
  input  wire logic       clk_sys_i,      // system clock, 10 MHz
  input  wire logic       reset_n_i,      // async reset, active low
  input  wire logic       key_on_i,       // key input pin, high is on
  input  wire logic       ilock_closed_i, // remote interlock pin, closed
  input  wire logic       temp_stable_i,  // temperature stable indication
  input  wire logic       keyless_i,      // variant strap, high keyless
  input  wire logic [7:0] rx_data_i,      // host byte
  input  wire logic       rx_valid_i,     // host byte valid
  output logic            rx_ready_o,     // host byte accepted
  output logic [7:0]      tx_data_o,      // reply byte
  output logic            tx_valid_o,     // reply byte valid
  input  wire logic       tx_ready_i,     // reply byte taken
  input  wire logic [3:0] reg_addr_i,     // register address
  input  wire logic [7:0] reg_wdata_i,    // register write data
  input  wire logic       reg_wr_i,       // register write strobe
  input  wire logic       reg_rd_i,       // register read strobe
  output logic [7:0]      reg_rdata_o,    // register read data
  output logic            laser_en_o,     // emission enable to lasers
  output logic            armed_o,        // emission armed indication
  output logic            cc_mode_o       // constant current mode
);

  // complete state of the block
  typedef struct packed {
    logic         key_s1;
    logic         key_s2;
    logic         key_prev;
    logic         lock_s1;
    logic         lock_s2;
    logic         temp_s1;
    logic         temp_s2;
    logic         var_s1;
    logic         var_s2;
    logic         keyless;
    logic [1:0]   pwr_cnt;
    eeh_em_type   em;
    logic         cc_mode;
    logic [7:0]   setp;
    eeh_cmd_type  cmd;
    logic [31:0]  msg;
    logic [2:0]   len;
    logic         ovf;
    logic         start;
    eeh_rply_type kind;
    logic [3:0]   d1;
    logic [3:0]   d0;
    logic         rx_ready;
    logic [7:0]   rdata;
    logic         laser_en;
    logic         armed;
  } eeh_top_st_type;

  eeh_top_st_type st;
  eeh_top_st_type next_st;

  eeh_rply_if rif ();

  // reply generator owns the outgoing byte stream
  eeh_rply u_rply (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .rif       (rif)
  );

  // request lines toward the reply generator
  assign rif.start    = st.start;
  assign rif.kind     = st.kind;
  assign rif.d1       = st.d1;
  assign rif.d0       = st.d0;
  assign rif.tx_ready = tx_ready_i;

  always_comb begin
    logic key_rise;
    logic do_pause;
    logic do_resume;
    logic rx_take;
    key_rise  = 1'b0;
    do_pause  = 1'b0;
    do_resume = 1'b0;
    rx_take   = 1'b0;
    next_st   = st;

    // pin synchronisers, second stage is the only reader of the first
    next_st.key_s1  = key_on_i;
    next_st.key_s2  = st.key_s1;
    next_st.lock_s1 = ilock_closed_i;
    next_st.lock_s2 = st.lock_s1;
    next_st.temp_s1 = temp_stable_i;
    next_st.temp_s2 = st.temp_s1;
    next_st.var_s1  = keyless_i;
    next_st.var_s2  = st.var_s1;

    // key transition from off to on
    next_st.key_prev = st.key_s2;
    key_rise = st.key_s2 && !st.key_prev;

    // register writes
    if (reg_wr_i) begin
      if (reg_addr_i == `EEH_REG_CTRL)
        next_st.cc_mode = reg_wdata_i[`EEH_CTRL_MODE_BIT];
      else if (reg_addr_i == `EEH_REG_SETP)
        next_st.setp = reg_wdata_i;
    end

    // register reads, data valid in the following cycle only
    next_st.rdata = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `EEH_REG_CTRL: next_st.rdata = {7'h00, st.cc_mode};
        `EEH_REG_SETP: next_st.rdata = st.setp;
        `EEH_REG_STAT: next_st.rdata = {st.keyless, st.lock_s2,
                                        st.key_s2, st.armed,
                                        st.laser_en, st.em};
        default:       next_st.rdata = 8'h00;
      endcase
    end

    // host message handling
    next_st.start = 1'b0;
    rx_take = (st.cmd == CMD_RX) && rx_valid_i && st.rx_ready;
    unique case (st.cmd)
      CMD_RX: begin
        if (rx_take) begin
          if (rx_data_i == `EEH_CHAR_CR) begin
            // one reply per message, and only then
            next_st.start = 1'b1;
            next_st.cmd   = CMD_LAUNCH;
            next_st.kind  = RPLY_OK;
            next_st.d1    = 4'h0;
            next_st.d0    = 4'h0;
            if (st.ovf) begin
              next_st.kind = RPLY_ERR;
            end else if (st.len == 3'h3 && st.msg[23:0] == "lor") begin
              do_pause = 1'b1;
            end else if (st.len == 3'h3 && st.msg[23:0] == "lrr") begin
              do_resume = 1'b1;
            end else if (st.len == 3'h2 && st.msg[15:0] == "cp") begin
              next_st.cc_mode = 1'b0;
            end else if (st.len == 3'h2 && st.msg[15:0] == "ci") begin
              next_st.cc_mode = 1'b1;
            end else if (st.len == 3'h2 && st.msg[15:0] == "l?") begin
              next_st.kind = RPLY_DIGIT;
              next_st.d0   = {3'h0, st.laser_en};
            end else if (st.len == 3'h2 && st.msg[15:0] == "p?") begin
              // set point as integer and tenths digit
              next_st.kind = RPLY_FIXED;
              next_st.d1   = st.setp[7:4];
              next_st.d0   = st.setp[3:0];
            end else begin
              next_st.kind = RPLY_ERR;
            end
            next_st.msg = 32'h0000_0000;
            next_st.len = 3'h0;
            next_st.ovf = 1'b0;
          end else if (st.len == `EEH_CMD_MAX) begin
            next_st.ovf = 1'b1;
          end else begin
            next_st.msg = {st.msg[23:0], rx_data_i};
            next_st.len = st.len + 3'h1;
          end
        end
      end
      CMD_LAUNCH: begin
        next_st.cmd = CMD_DRAIN;
      end
      CMD_DRAIN: begin
        // next message waits until the reply is out
        if (!rif.busy)
          next_st.cmd = CMD_RX;
      end
      default: begin
        // unused code, fall back to waiting for a message
        next_st.cmd = CMD_RX;
      end
    endcase
    next_st.rx_ready = (next_st.cmd == CMD_RX);

    // emission sequencing
    unique case (st.em)
      EM_POWERUP: begin
        if (st.pwr_cnt == `EEH_PWRUP_CYC) begin
          next_st.keyless = st.var_s2;
          if (st.var_s2)
            next_st.em = EM_WARMUP;
          else
            next_st.em = EM_STANDBY;
        end else begin
          next_st.pwr_cnt = st.pwr_cnt + 2'h1;
        end
      end
      EM_STANDBY: begin
        if (!st.keyless && key_rise && st.lock_s2)
          next_st.em = EM_ON;
      end
      EM_WARMUP: begin
        if (st.temp_s2 && st.lock_s2)
          next_st.em = EM_ON;
      end
      EM_ON: begin
        if (do_pause)
          next_st.em = EM_PAUSED;
      end
      EM_PAUSED: begin
        // mode and set points were never touched by the pause
        if (do_resume)
          next_st.em = EM_ON;
      end
      EM_LOCKED: begin
        if (st.lock_s2)
          next_st.em = st.keyless ? EM_WARMUP : EM_STANDBY;
      end
      default: begin
        // unused code, lasers stay off until the interlock is seen
        next_st.em = EM_LOCKED;
      end
    endcase

    // key off forces standby in the keyed variant
    if (st.em != EM_POWERUP && !st.keyless && !st.key_s2)
      next_st.em = EM_STANDBY;

    // open interlock overrides key and host commands
    if (st.em != EM_POWERUP && !st.lock_s2)
      next_st.em = EM_LOCKED;

    // outputs follow the next emission state
    next_st.laser_en = (next_st.em == EM_ON);
    next_st.armed    = (next_st.em == EM_ON) ||
                       (next_st.em == EM_PAUSED);
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st      <= '0;
      st.setp <= `EEH_SETP_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign rx_ready_o  = st.rx_ready;
  assign tx_data_o   = rif.tx_data;
  assign tx_valid_o  = rif.tx_valid;
  assign reg_rdata_o = st.rdata;
  assign laser_en_o  = st.laser_en;
  assign armed_o     = st.armed;
  assign cc_mode_o   = st.cc_mode;

endmodule : eeh_top

// ### rtl/eeh_map.svh
`ifndef EEH_MAP_SVH
`define EEH_MAP_SVH

// register offsets on the plain register port
`define EEH_REG_CTRL   4'h0
`define EEH_REG_SETP   4'h1
`define EEH_REG_STAT   4'h2

// field positions and reset values
`define EEH_CTRL_MODE_BIT 0
`define EEH_SETP_RST      8'h10

// characters and lengths of the host and reply streams
`define EEH_CHAR_CR    8'h0d
`define EEH_CHAR_DOT   8'h2e
`define EEH_CHAR_ZERO  8'h30
`define EEH_ERR_LEN    5'h1d
`define EEH_CMD_MAX    3'h4

// cycles after reset before the variant strap is taken
`define EEH_PWRUP_CYC  2'h3

`endif

// ### rtl/eeh_pkg.sv
package eeh_pkg;

  // emission sequencing states
  typedef enum logic [2:0] {
    EM_POWERUP, EM_STANDBY, EM_WARMUP, EM_ON, EM_PAUSED, EM_LOCKED
  } eeh_em_type;

  // host message handling phases
  typedef enum logic [1:0] {CMD_RX, CMD_LAUNCH, CMD_DRAIN} eeh_cmd_type;

  // kinds of reply string
  typedef enum logic [1:0] {
    RPLY_OK, RPLY_ERR, RPLY_DIGIT, RPLY_FIXED
  } eeh_rply_type;

  // state of the reply generator
  typedef struct packed {
    logic         busy;
    eeh_rply_type kind;
    logic [3:0]   d1;
    logic [3:0]   d0;
    logic [4:0]   idx;
    logic [7:0]   tx_data;
    logic         tx_valid;
  } eeh_rply_st_type;

endpackage : eeh_pkg

// ### rtl/eeh_rply_if.sv
`timescale 1ns/100ps

interface eeh_rply_if;
  import eeh_pkg::*;
  logic         start;
  eeh_rply_type kind;
  logic [3:0]   d1;
  logic [3:0]   d0;
  logic         busy;
  logic [7:0]   tx_data;
  logic         tx_valid;
  logic         tx_ready;

  modport ctrl (output start, kind, d1, d0, tx_ready,
                input  busy, tx_data, tx_valid);
  modport gen  (input  start, kind, d1, d0, tx_ready,
                output busy, tx_data, tx_valid);
endinterface : eeh_rply_if

// ### rtl/eeh_rply.sv
`timescale 1ns/100ps
`include "eeh_map.svh"

module eeh_rply
  import eeh_pkg::*;
(
  input  wire logic  clk_sys_i, // system clock
  input  wire logic  reset_n_i, // async reset, active low
  eeh_rply_if.gen    rif        // reply request and byte stream
);

  localparam logic [8*29-1:0] ERR_MSG = "Syntax error: illegal command";
  localparam logic [15:0]     OK_MSG  = "OK";

  eeh_rply_st_type st;
  eeh_rply_st_type next_st;

  // character at position i of a reply, carriage return past the end
  function automatic logic [7:0] char_at(eeh_rply_type k,
                                         logic [4:0] i,
                                         logic [3:0] a,
                                         logic [3:0] b);
    logic [7:0] c;
    c = `EEH_CHAR_CR;
    unique case (k)
      RPLY_OK: begin
        if (i == 5'h0) c = OK_MSG[15:8];
        else if (i == 5'h1) c = OK_MSG[7:0];
      end
      RPLY_ERR: begin
        if (i < `EEH_ERR_LEN)
          c = ERR_MSG[8*(5'h1c - i) +: 8];
      end
      RPLY_DIGIT: begin
        if (i == 5'h0) c = `EEH_CHAR_ZERO + {4'h0, b};
      end
      RPLY_FIXED: begin
        if (i == 5'h0) c = `EEH_CHAR_ZERO + {4'h0, a};
        else if (i == 5'h1) c = `EEH_CHAR_DOT;
        else if (i == 5'h2) c = `EEH_CHAR_ZERO + {4'h0, b};
      end
    endcase
    return c;
  endfunction : char_at

  // start a reply, step through it, stop after the carriage return
  always_comb begin
    next_st = st;
    if (!st.busy) begin
      if (rif.start) begin
        next_st.busy     = 1'b1;
        next_st.kind     = rif.kind;
        next_st.d1       = rif.d1;
        next_st.d0       = rif.d0;
        next_st.idx      = 5'h0;
        next_st.tx_data  = char_at(rif.kind, 5'h0, rif.d1, rif.d0);
        next_st.tx_valid = 1'b1;
      end
    end else if (st.tx_valid && rif.tx_ready) begin
      if (st.tx_data == `EEH_CHAR_CR) begin
        next_st.busy     = 1'b0;
        next_st.tx_valid = 1'b0;
      end else begin
        next_st.idx     = st.idx + 5'h1;
        next_st.tx_data = char_at(st.kind, st.idx + 5'h1, st.d1, st.d0);
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rif.busy     = st.busy;
  assign rif.tx_data  = st.tx_data;
  assign rif.tx_valid = st.tx_valid;

endmodule : eeh_rply

// ### verif/eeh_top_sva.sv
`timescale 1ns/100ps

module eeh_top_sva (
  input wire logic       clk_sys_i,      // clock
  input wire logic       reset_n_i,      // reset, active low
  input wire logic       key_on_i,       // key pin
  input wire logic       ilock_closed_i, // interlock pin
  input wire logic       keyless_i,      // variant strap
  input wire logic [7:0] rx_data_i,      // host byte
  input wire logic       rx_valid_i,     // host byte valid
  input wire logic       rx_ready_o,     // host byte accepted
  input wire logic [7:0] tx_data_o,      // reply byte
  input wire logic       tx_valid_o,     // reply byte valid
  input wire logic       tx_ready_i,     // reply byte taken
  input wire logic       reg_rd_i,       // read strobe
  input wire logic [7:0] reg_rdata_o,    // read data
  input wire logic       laser_en_o,     // emission enable
  input wire logic       armed_o         // armed indication
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // end of a host message and end of a reply
  wire rx_cr = rx_valid_i && rx_ready_o && rx_data_i == 8'h0d;
  wire tx_cr = tx_valid_o && tx_ready_i && tx_data_o == 8'h0d;

  a_no_unasked_tx: assert property ($rose(tx_valid_o) |-> !rx_ready_o)
    else $error("reply byte without a pending message");
  a_reply_start: assert property (rx_cr |-> ##2 tx_valid_o)
    else $error("reply did not start two cycles after message end");
  a_one_at_time: assert property (rx_cr |=> !rx_ready_o [*4])
    else $error("host byte accepted during a reply");
  a_cr_closes: assert property (tx_cr |=> !tx_valid_o ##1 rx_ready_o)
    else $error("reply not closed after carriage return");
  a_byte_holds: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped before taken");
  a_ilock_stops: assert property (!ilock_closed_i [*5] |->
    !laser_en_o && !armed_o)
    else $error("lasers on with interlock open");
  a_key_standby: assert property ((!keyless_i && !key_on_i) [*5] |->
    !laser_en_o)
    else $error("emission with key off");
  a_key_starts: assert property (ilock_closed_i [*8] ##0
    (!keyless_i && $rose(key_on_i)) |-> ##[1:8] laser_en_o)
    else $error("key turn did not start emission");
  a_armed_follows: assert property (laser_en_o |-> armed_o)
    else $error("emission without armed indication");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read answer cycle");

  c_reply: cover property (tx_cr);
  c_pause: cover property (armed_o && !laser_en_o);
  c_ilock: cover property (laser_en_o ##1 !ilock_closed_i);
endmodule : eeh_top_sva

bind eeh_top eeh_top_sva eeh_top_sva_i (
  .clk_sys_i, .reset_n_i, .key_on_i, .ilock_closed_i, .keyless_i,
  .rx_data_i, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o,
  .tx_ready_i, .reg_rd_i, .reg_rdata_o, .laser_en_o, .armed_o
);

// ### verif/eeh_host.sv
`timescale 1ns/100ps

module eeh_host (
  input  wire logic       clk_i,      // system clock
  input  wire logic       stall_i,    // hold off reply bytes
  output logic [7:0]      rx_data_o,  // byte to the device
  output logic            rx_valid_o, // byte valid
  input  wire logic       rx_ready_i, // device took byte
  input  wire logic [7:0] tx_data_i,  // reply byte
  input  wire logic       tx_valid_i, // reply byte valid
  output logic            tx_ready_o  // reply byte taken
);
  // host may stall the reply stream in any cycle
  assign tx_ready_o = ~stall_i;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // send one message, then collect its reply up to the carriage return
  task automatic xfer(input string msg, output string rep);
    string s;
    int    n;
    s = {msg, "\015"};
    rep = "";
    for (int k = 0; k < s.len(); k++) begin
      rx_data_o <= s[k];
      rx_valid_o <= 1'b1;
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~rx_data_o; // released line shows no stale byte
    n = 0;
    while (n < 300) begin
      @(posedge clk_i);
      n++;
      if (tx_valid_i && tx_ready_o) begin
        rep = {rep, string'(tx_data_i)};
        if (tx_data_i == 8'h0d) n = 1000;
      end
    end
  endtask : xfer
endmodule : eeh_host

// ### verif/eeh_top_tb.sv
`timescale 1ns/100ps

module eeh_top_tb;
  logic       clk_sys_i, reset_n_i, key_on_i, ilock_closed_i, stall;
  logic       temp_stable_i, keyless_i, rx_valid_i, rx_ready_o;
  logic       tx_valid_o, tx_ready_i, reg_wr_i, reg_rd_i;
  logic       laser_en_o, armed_o, cc_mode_o;
  logic [7:0] rx_data_i, tx_data_o, reg_wdata_i, reg_rdata_o, v;
  logic [3:0] reg_addr_i;
  int         err_total, num_checks, m_en, m_armed, m_cc, m_pause;
  int         m_d1, m_d0;
  int         seed = 32'h9fa661b5;
  string      rep;
  string      seq [11] = '{"ci", "lor", "p?", "l?", "lrr", "cp", "xyz",
                           "", "lorr", "lorr5", "lr"};

  eeh_top eeh_top_i (.clk_sys_i, .reset_n_i, .key_on_i, .ilock_closed_i,
    .temp_stable_i, .keyless_i, .rx_data_i, .rx_valid_i, .rx_ready_o,
    .tx_data_o, .tx_valid_o, .tx_ready_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .laser_en_o, .armed_o, .cc_mode_o);
  eeh_host eeh_host_i (.clk_i(clk_sys_i), .stall_i(stall),
    .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
    .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));

  // 10 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // random stalls of the reply stream
  always @(posedge clk_sys_i) stall <= ($random(seed) & 3) == 0;

  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      $display("MISMATCH at %0t: %s", $time, msg);
      err_total++;
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // reference reply for a message in the present model state
  function automatic string expect_rep(input string m);
    string r;
    case (m)
      "l?": r = m_en ? "1" : "0";
      "p?": r = $sformatf("%0d.%0d", m_d1, m_d0);
      "lor", "lrr", "cp", "ci": r = "OK";
      default: r = "Syntax error: illegal command";
    endcase
    return {r, "\015"};
  endfunction : expect_rep

  // one host message, reply and outputs compared with the model
  task automatic cmd(input string m);
    string e;
    e = expect_rep(m);
    eeh_host_i.xfer(m, rep);
    chk(rep == e, {"reply to ", m});
    if (m == "lor" && m_en) begin
      m_en = 0;
      m_pause = 1;
    end
    if (m == "lrr" && m_pause) begin
      m_en = 1;
      m_pause = 0;
    end
    if (m == "cp") m_cc = 0;
    if (m == "ci") m_cc = 1;
    repeat (2) @(posedge clk_sys_i);
    chk({laser_en_o, armed_o, cc_mode_o} === {m_en[0], m_armed[0], m_cc[0]},
        {"outputs after ", m});
  endtask : cmd

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    d = reg_rdata_o;
  endtask : reg_rd

  task automatic rst(input logic k);
    reset_n_i <= 1'b0;
    keyless_i <= k;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    {m_en, m_armed, m_cc, m_pause, m_d1, m_d0} = {32'd0, 32'd0, 32'd0,
                                                 32'd0, 32'd1, 32'd0};
  endtask : rst

  // main sequence: keyed variant, then keyless variant
  initial begin
    {reset_n_i, key_on_i, temp_stable_i, keyless_i} = 4'h0;
    ilock_closed_i = 1'b1;
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = 14'h0000;
    rst(1'b0);
    repeat (10) @(posedge clk_sys_i);
    cmd("l?");
    key_on_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    {m_en, m_armed} = {32'd1, 32'd1};
    cmd("p?");
    m_d1 = {$random(seed)} % 10;
    m_d0 = {$random(seed)} % 10;
    reg_wr(4'h1, {m_d1[3:0], m_d0[3:0]});
    reg_rd(4'h1, v);
    chk(v === {m_d1[3:0], m_d0[3:0]}, "setpoint readback");
    foreach (seq[i]) cmd(seq[i]);
    reg_rd(4'h2, v);
    chk(v === 8'h7b, "status on");
    reg_rd(4'hf, v);
    chk(v === 8'h00, "unmapped read");
    reg_wr(4'h0, 8'h01);
    m_cc = 1;
    reg_rd(4'h0, v);
    chk(v[0] === 1'b1 && cc_mode_o === 1'b1, "mode register");
    ilock_closed_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    {m_en, m_armed} = {32'd0, 32'd0};
    cmd("lrr");
    ilock_closed_i <= 1'b1;
    key_on_i <= 1'b0;
    rst(1'b1);
    repeat (20) @(posedge clk_sys_i);
    cmd("l?");
    reg_rd(4'h2, v);
    chk(v === 8'hc2, "keyless warming up");
    temp_stable_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    {m_en, m_armed} = {32'd1, 32'd1};
    cmd("l?");
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    conclude();
  end
endmodule : eeh_top_tb
